/* verilog/spim_consts.vh */
// Constants for the SPI master with transmit and receive FIFOs
`ifndef SPIM_CONSTS_VH
`define SPIM_CONSTS_VH
// ==========================================================
// Register indices (byte address is four times the index)
`define SPIM_IDX_DATA 8'hB8
`define SPIM_IDX_CTRL 8'hB9
`define SPIM_IDX_STAT 8'hBA
`define SPIM_IDX_DIV 8'hBB
// ==========================================================
// Control register fields and reset value
`define SPIM_CTRL_IRQ_EN 6
`define SPIM_CTRL_SEL 5
`define SPIM_CTRL_SS_ACT 4
`define SPIM_CTRL_OVF_MSK 3
`define SPIM_CTRL_EMT_MSK 2
`define SPIM_CTRL_CPOL 1
`define SPIM_CTRL_CPHA 0
`define SPIM_CTRL_RST 7'h0C
// ==========================================================
// Status register fields
`define SPIM_STAT_TX_EMPTY 7
`define SPIM_STAT_TX_FULL 6
`define SPIM_STAT_RX_EMPTY 5
`define SPIM_STAT_RX_FULL 4
`define SPIM_STAT_OVF 3
`define SPIM_STAT_EMT 2
// ==========================================================
// Divisor reset, FIFO geometry, index of the last edge of a byte
`define SPIM_DIV_RST 8'h03
`define SPIM_FIFO_DEPTH 16
`define SPIM_FIFO_AW 4
`define SPIM_LAST_EDGE 4'hF
`endif

/* verilog/spim_fifo.v */
// Byte FIFO, 16 entries, with flush
`timescale 1ns/1ps
`default_nettype none
`include "spim_consts.vh"
module spim_fifo (
    input wire clock_i,
    input wire reset_i,
    input wire flush_i,
    input wire push_i,
    input wire [7:0] din_i,
    input wire pop_i,
    output wire [7:0] dout_o,
    output wire empty_o,
    output wire full_o
);
    reg [7:0] mem [0:`SPIM_FIFO_DEPTH-1];
    reg [`SPIM_FIFO_AW:0] wptr_q;
    reg [`SPIM_FIFO_AW:0] rptr_q;

    // ==========================================================
    // Flags from the extra pointer bit
    assign empty_o = (wptr_q == rptr_q);
    assign full_o = (wptr_q[`SPIM_FIFO_AW] != rptr_q[`SPIM_FIFO_AW]) &&
        (wptr_q[`SPIM_FIFO_AW-1:0] == rptr_q[`SPIM_FIFO_AW-1:0]);
    assign dout_o = mem[rptr_q[`SPIM_FIFO_AW-1:0]];

    // Storage has no reset; only pointers matter
    always @(posedge clock_i) begin
        if (push_i && !full_o) begin
            mem[wptr_q[`SPIM_FIFO_AW-1:0]] <= din_i;
        end
    end

    // Pointers; flush beats push and pop
    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            wptr_q <= 5'h00;
            rptr_q <= 5'h00;
        end else if (flush_i) begin
            wptr_q <= 5'h00;
            rptr_q <= 5'h00;
        end else begin
            if (push_i && !full_o) begin
                wptr_q <= wptr_q + 5'h01;
            end
            if (pop_i && !empty_o) begin
                rptr_q <= rptr_q + 5'h01;
            end
        end
    end
endmodule // spim_fifo
`default_nettype wire

/* verilog/spim_clkdiv.v */
// Half-period tick generator for the serial clock
`timescale 1ns/1ps
`default_nettype none
module spim_clkdiv (
    input wire clock_i,
    input wire reset_i,
    input wire run_i,
    input wire [7:0] div_i,
    output wire tick_o
);
    reg [7:0] cnt_q;

    // One tick every divisor plus one cycles while running
    assign tick_o = run_i && (cnt_q == div_i);

    // Restarts from zero so each byte gets full first half-period
    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_q <= 8'h00;
        end else if (!run_i || tick_o) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule // spim_clkdiv
`default_nettype wire

/* verilog/spim_top.v */
// SPI master with FIFOs behind an AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "spim_consts.vh"
module spim_top (
    input wire clock_i,
    input wire reset_i,
    input wire hsel_i,
    input wire [31:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [2:0] hsize_i,
    input wire hready_i,
    input wire [31:0] hwdata_i,
    output wire [31:0] hrdata_o,
    output wire hreadyout_o,
    output wire hresp_o,
    output wire irq_o,
    output wire sck_o,
    output wire mosi_o,
    input wire miso_i,
    output wire flash_select_0_n_o,
    output wire flash_select_1_n_o
);
    // ==========================================================
    // Engine states
    localparam ST_IDLE = 2'b00;
    localparam ST_SHIFT = 2'b01;
    localparam ST_DONE = 2'b10;

    // ==========================================================
    // Bus slave state
    reg act_q;
    reg wr_q;
    reg [7:0] idx_q;
    reg hreadyout_q;
    reg [31:0] hrdata_q;
    reg hresp_q;

    // ==========================================================
    // Registers
    reg [6:0] ctrl_q;
    reg [7:0] div_q;
    reg ovf_q;
    reg emt_q;
    reg emt_cond_prev_q;
    reg irq_q;

    // ==========================================================
    // Engine and pins
    reg [1:0] state_q;
    reg [3:0] edge_q;
    reg [7:0] tx_sh_q;
    reg [7:0] rx_sh_q;
    reg sck_q;
    reg mosi_q;
    reg cs0_n_q;
    reg cs1_n_q;

    // ==========================================================
    // Decoded controls and FIFO handshakes
    wire ss_act;
    wire cpol;
    wire cpha;
    wire wr_phase;
    wire rd_phase;
    wire wr_data;
    wire rd_data;
    wire wr_ctrl;
    wire wr_stat;
    wire wr_div;
    wire tx_push;
    wire tx_pop;
    wire tx_empty;
    wire tx_full;
    wire [7:0] tx_dout;
    wire rx_push;
    wire rx_pop;
    wire rx_empty;
    wire rx_full;
    wire [7:0] rx_dout;
    wire tick;
    wire sample_edge;
    wire ovf_set;
    wire emt_cond;
    wire emt_set;
    wire [7:0] status;

    assign ss_act = ctrl_q[`SPIM_CTRL_SS_ACT];
    assign cpol = ctrl_q[`SPIM_CTRL_CPOL];
    assign cpha = ctrl_q[`SPIM_CTRL_CPHA];

    // Data phase is the single cycle after an accepted address
    assign wr_phase = act_q && wr_q;
    assign rd_phase = act_q && !wr_q;
    assign wr_data = wr_phase && (idx_q == `SPIM_IDX_DATA);
    assign rd_data = rd_phase && (idx_q == `SPIM_IDX_DATA);
    assign wr_ctrl = wr_phase && (idx_q == `SPIM_IDX_CTRL);
    assign wr_stat = wr_phase && (idx_q == `SPIM_IDX_STAT);
    assign wr_div = wr_phase && (idx_q == `SPIM_IDX_DIV);

    // ==========================================================
    // FIFO traffic
    assign tx_push = wr_data && !tx_full;
    assign tx_pop = (state_q == ST_IDLE) && ss_act && !tx_empty;
    assign rx_push = (state_q == ST_DONE) && !rx_full;
    assign rx_pop = rd_data && !rx_empty;

    // Dropped bytes in either direction raise overflow
    assign ovf_set = (wr_data && tx_full) ||
        ((state_q == ST_DONE) && rx_full);

    // Edge detect so a clear sticks while the engine stays idle
    assign emt_cond = tx_empty && (state_q == ST_IDLE);
    assign emt_set = emt_cond && !emt_cond_prev_q;

    // Live status image
    assign status = {tx_empty, tx_full, rx_empty, rx_full,
        ovf_q, emt_q, 2'b00};

    // Leading edges are even; phase 0 samples on them
    assign sample_edge = (edge_q[0] == cpha);

    // ==========================================================
    // Transmit FIFO, held empty while select is inactive
    spim_fifo u_tx_fifo (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .flush_i(!ss_act),
        .push_i(tx_push),
        .din_i(hwdata_i[7:0]),
        .pop_i(tx_pop),
        .dout_o(tx_dout),
        .empty_o(tx_empty),
        .full_o(tx_full)
    );

    // Receive FIFO, flushed with the transmit FIFO while select is inactive
    spim_fifo u_rx_fifo (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .flush_i(!ss_act),
        .push_i(rx_push),
        .din_i(rx_sh_q),
        .pop_i(rx_pop),
        .dout_o(rx_dout),
        .empty_o(rx_empty),
        .full_o(rx_full)
    );

    // Serial clock half-period timer
    spim_clkdiv u_clkdiv (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .run_i(state_q == ST_SHIFT),
        .div_i(div_q),
        .tick_o(tick)
    );

    // ==========================================================
    // AHB-Lite slave: one wait state on every transfer so read
    // data can come from a flop; size is ignored, low byte used
    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            act_q <= 1'b0;
            wr_q <= 1'b0;
            idx_q <= 8'h00;
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end else begin
            hresp_q <= 1'b0;
            if (hready_i && hsel_i && htrans_i[1]) begin
                act_q <= 1'b1;
                wr_q <= hwrite_i;
                idx_q <= haddr_i[9:2];
                hreadyout_q <= 1'b0;
            end else if (act_q) begin
                act_q <= 1'b0;
                hreadyout_q <= 1'b1;
            end
        end
    end

    // Read mux; unmapped and empty reads return zero
    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            hrdata_q <= 32'h0000_0000;
        end else if (rd_phase) begin
            case (idx_q)
                `SPIM_IDX_DATA: hrdata_q <= {24'h000000,
                    (rx_empty ? 8'h00 : rx_dout)};
                `SPIM_IDX_CTRL: hrdata_q <= {25'h0000000, ctrl_q};
                `SPIM_IDX_STAT: hrdata_q <= {24'h000000, status};
                `SPIM_IDX_DIV: hrdata_q <= {24'h000000, div_q};
                default: hrdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // Control and divisor registers
    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            ctrl_q <= `SPIM_CTRL_RST;
            div_q <= `SPIM_DIV_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= hwdata_i[6:0];
            end
            if (wr_div) begin
                div_q <= hwdata_i[7:0];
            end
        end
    end

    // Sticky flags: a set in the clearing cycle wins
    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            ovf_q <= 1'b0;
            emt_q <= 1'b0;
            emt_cond_prev_q <= 1'b1;
        end else begin
            emt_cond_prev_q <= emt_cond;
            if (ovf_set) begin
                ovf_q <= 1'b1;
            end else if (wr_stat && hwdata_i[`SPIM_STAT_OVF]) begin
                ovf_q <= 1'b0;
            end
            if (emt_set) begin
                emt_q <= 1'b1;
            end else if (wr_stat && hwdata_i[`SPIM_STAT_EMT]) begin
                emt_q <= 1'b0;
            end
        end
    end

    // Interrupt: enable gates it, flags still update underneath
    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= ctrl_q[`SPIM_CTRL_IRQ_EN] &&
                ((ovf_q && !ctrl_q[`SPIM_CTRL_OVF_MSK]) ||
                (emt_q && !ctrl_q[`SPIM_CTRL_EMT_MSK]));
        end
    end

    // ==========================================================
    // Slave select pins: unselected pin always high
    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            cs0_n_q <= 1'b1;
            cs1_n_q <= 1'b1;
        end else begin
            cs0_n_q <= !(ss_act && !ctrl_q[`SPIM_CTRL_SEL]);
            cs1_n_q <= !(ss_act && ctrl_q[`SPIM_CTRL_SEL]);
        end
    end

    // ==========================================================
    // Byte engine: 16 clock edges per byte. Mode is read live,
    // so changing it mid-byte corrupts that byte
    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            state_q <= ST_IDLE;
            edge_q <= 4'h0;
            tx_sh_q <= 8'h00;
            rx_sh_q <= 8'h00;
            sck_q <= 1'b0;
            mosi_q <= 1'b0;
        end else if (!ss_act) begin
            state_q <= ST_IDLE;
            edge_q <= 4'h0;
            sck_q <= cpol;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    sck_q <= cpol;
                    edge_q <= 4'h0;
                    if (tx_pop) begin
                        tx_sh_q <= tx_dout;
                        state_q <= ST_SHIFT;
                        if (!cpha) begin
                            // Phase 0 needs bit 7 before the first edge
                            mosi_q <= tx_dout[7];
                            tx_sh_q <= {tx_dout[6:0], 1'b0};
                        end
                    end
                end
                ST_SHIFT: begin
                    if (tick) begin
                        sck_q <= !sck_q;
                        edge_q <= edge_q + 4'h1;
                        if (sample_edge) begin
                            rx_sh_q <= {rx_sh_q[6:0], miso_i};
                        end else if (edge_q != `SPIM_LAST_EDGE) begin
                            mosi_q <= tx_sh_q[7];
                            tx_sh_q <= {tx_sh_q[6:0], 1'b0};
                        end
                        if (edge_q == `SPIM_LAST_EDGE) begin
                            state_q <= ST_DONE;
                        end
                    end
                end
                ST_DONE: begin
                    // Captured byte is pushed this cycle
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Outputs straight from flops
    assign hrdata_o = hrdata_q;
    assign hreadyout_o = hreadyout_q;
    assign hresp_o = hresp_q;
    assign irq_o = irq_q;
    assign sck_o = sck_q;
    assign mosi_o = mosi_q;
    assign flash_select_0_n_o = cs0_n_q;
    assign flash_select_1_n_o = cs1_n_q;
endmodule // spim_top
`default_nettype wire

/* tb/spim_properties.sv */
// Concurrent checks on the SPI master ports
`timescale 1ns/1ps
`default_nettype none
`include "spim_consts.vh"
module spim_properties (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic [31:0] hwdata_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic irq_o,
    input wire logic sck_o,
    input wire logic mosi_o,
    input wire logic flash_select_0_n_o,
    input wire logic flash_select_1_n_o
);
    wire take = hsel_i && htrans_i[1] && hready_i;
    logic ph_q, wr_q, sck_q;
    logic [7:0] idx_q, div_q;
    logic [6:0] ctl_q;
    logic [15:0] gap_q;
    // ==========================================================
    // Shadow of control and divisor, written on the design's own edge
    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            ph_q <= 1'b0;
            wr_q <= 1'b0;
            idx_q <= 8'h00;
            ctl_q <= `SPIM_CTRL_RST;
            div_q <= `SPIM_DIV_RST;
            sck_q <= 1'b0;
            gap_q <= 16'h0000;
        end else begin
            ph_q <= take;
            if (take) begin
                wr_q <= hwrite_i;
                idx_q <= haddr_i[9:2];
            end
            if (ph_q && wr_q && idx_q == `SPIM_IDX_CTRL) ctl_q <= hwdata_i[6:0];
            if (ph_q && wr_q && idx_q == `SPIM_IDX_DIV) div_q <= hwdata_i[7:0];
            sck_q <= sck_o;
            // Saturates so long idle spells never wrap into a false short gap
            if (sck_o != sck_q) gap_q <= 16'h0000;
            else if (gap_q != 16'hFFFF) gap_q <= gap_q + 16'h0001;
        end
    end
    // ==========================================================
    // Properties
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);
    sequence s_take;
        hsel_i && htrans_i[1] && hready_i;
    endsequence
    sequence s_answer;
        !hreadyout_o ##1 hreadyout_o;
    endsequence
    bus_answer_a: assert property (s_take |=> s_answer)
        else $error("bus answer timing wrong");
    ready_idle_a: assert property (!$past(take) |-> hreadyout_o)
        else $error("wait state without a transfer");
    resp_okay_a: assert property (hresp_o == 1'b0)
        else $error("response not okay");
    rdata_upper_a: assert property (hrdata_o[31:8] == 24'h000000)
        else $error("read data upper bits set");
    sel_route_a: assert property (
        flash_select_0_n_o == !($past(ctl_q[4]) && !$past(ctl_q[5]))
        && flash_select_1_n_o == !($past(ctl_q[4]) && $past(ctl_q[5])))
        else $error("select pins disagree with control");
    sck_rest_a: assert property (!ctl_q[4] && !$past(ctl_q[4]) && $stable(ctl_q[1])
        |-> sck_o == ctl_q[1])
        else $error("serial clock not at rest level");
    irq_gate_a: assert property (!$past(ctl_q[6]) |-> !irq_o)
        else $error("interrupt while disabled");
    mosi_hold_a: assert property (ctl_q[4] && $stable(ctl_q[1:0])
        && (ctl_q[1] == ctl_q[0] ? $rose(sck_o) : $fell(sck_o)) |-> $stable(mosi_o))
        else $error("data changed on sample edge");
    half_period_a: assert property ((sck_o != sck_q) && ctl_q[4] && $past(ctl_q[4])
        && $stable(ctl_q[1]) |-> gap_q >= {8'h00, div_q})
        else $error("serial clock half period too short");
    // Inside a pulse the clock must come back within one half period
    pulse_width_a: assert property (ctl_q[4] && $past(ctl_q[4]) && $stable(div_q)
        && $stable(ctl_q[1:0]) && (sck_o == sck_q) && (sck_o != ctl_q[1])
        |-> gap_q <= {8'h00, div_q})
        else $error("serial clock half period too long");
endmodule // spim_properties
bind spim_top spim_properties u_spim_properties (.*);
`default_nettype wire

/* tb/spim_slave_model.sv */
// Behavioural SPI slave that answers each byte with the one before it
`timescale 1ns/1ps
`default_nettype none
module spim_slave_model (
    input wire logic sck_i,
    input wire logic sel_n_i,
    input wire logic mosi_i,
    input wire logic cpol_i,
    input wire logic cpha_i,
    output logic miso_o
);
    logic [7:0] rx_q = 8'h00;
    logic [7:0] tx_q = 8'hC3;
    logic [7:0] last_q = 8'hC3;
    integer n = 0;
    initial miso_o = 1'b0;
    // ==========================================================
    // New byte on select; a released line flips so it never looks valid
    always @(sel_n_i) begin
        n = 0;
        tx_q = last_q;
        miso_o = sel_n_i ? ~miso_o : tx_q[7];
    end
    // Sample and change edges follow the mode, MSB first
    always @(sck_i) begin
        if (!sel_n_i && sck_i == (cpol_i ~^ cpha_i)) begin
            rx_q = {rx_q[6:0], mosi_i};
            n = n + 1;
            if (n == 8) begin
                n = 0;
                last_q = rx_q;
            end
        end else if (!sel_n_i) begin
            tx_q = (n == 0) ? last_q : tx_q << 1;
            miso_o = tx_q[7];
        end
    end
endmodule // spim_slave_model
`default_nettype wire

/* tb/tb_spim_top.sv */
// Self-checking bench for the SPI master with FIFOs
`timescale 1ns/1ps
`default_nettype none
`include "spim_consts.vh"
module tb_spim_top;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic hsel_i = 1'b0;
    logic [31:0] haddr_i = 32'h0;
    logic [1:0] htrans_i = 2'h0;
    logic hwrite_i = 1'b0;
    logic [31:0] hwdata_i = 32'h0;
    logic [1:0] mode_q = 2'h0;
    logic [31:0] seed = 32'h48;
    logic [7:0] rd, prev = 8'hC3;
    logic [7:0] exp_q [$];
    integer err_count = 0, compares = 0, cyc = 0, i, k;
    wire [31:0] hrdata_o;
    wire hreadyout_o, hresp_o, irq_o, sck_o, mosi_o, miso_i;
    wire flash_select_0_n_o, flash_select_1_n_o;
    spim_top u_spim_top (.clock_i(clock_i), .reset_i(reset_i), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
        .hready_i(hreadyout_o), .hwdata_i(hwdata_i), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .irq_o(irq_o), .sck_o(sck_o),
        .mosi_o(mosi_o), .miso_i(miso_i), .flash_select_0_n_o(flash_select_0_n_o),
        .flash_select_1_n_o(flash_select_1_n_o));
    spim_slave_model u_spim_slave_model (.sck_i(sck_o),
        .sel_n_i(flash_select_0_n_o & flash_select_1_n_o), .mosi_i(mosi_o),
        .cpol_i(mode_q[1]), .cpha_i(mode_q[0]), .miso_o(miso_i));
    // ==========================================================
    // Clock and watchdog
    always #10 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        cyc = cyc + 1;
        if (cyc == 60000) begin
            err_count = err_count + 1;
            give_verdict();
        end
    end
    // ==========================================================
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic chk(input logic [7:0] act, input logic [7:0] exp);
        compares = compares + 1;
        if (act !== exp) begin
            err_count = err_count + 1;
            $display("ERROR t=%0t got %h exp %h", $time, act, exp);
        end
    endtask
    // Holds each phase until ready is sampled high
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        hsel_i <= 1'b1;
        haddr_i <= {22'h0, idx, 2'h0};
        htrans_i <= 2'h2;
        hwrite_i <= wr;
        @(posedge clock_i);
        while (hreadyout_o !== 1'b1) @(posedge clock_i);
        htrans_i <= 2'h0;
        hwdata_i <= {24'h0, wd};
        @(posedge clock_i);
        while (hreadyout_o !== 1'b1) @(posedge clock_i);
        rd = hrdata_o[7:0];
    endtask
    // Echo slave: each reply is the byte sent before it
    task automatic send(input integer n);
        for (i = 0; i < n; i = i + 1) begin
            seed = xs(seed);
            bus(1'b1, `SPIM_IDX_DATA, seed[7:0]);
            exp_q.push_back(prev);
            prev = seed[7:0];
        end
        do bus(1'b0, `SPIM_IDX_STAT, 8'h00); while (rd[2] !== 1'b1);
        bus(1'b1, `SPIM_IDX_STAT, 8'h04);
    endtask
    task automatic recv;
        while (exp_q.size() > 0) begin
            bus(1'b0, `SPIM_IDX_DATA, 8'h00);
            chk(rd, exp_q.pop_front());
        end
    endtask
    task automatic irq_is(input logic [7:0] ctl, input logic [7:0] exp);
        bus(1'b1, `SPIM_IDX_CTRL, ctl);
        repeat (2) @(posedge clock_i);
        chk({7'h0, irq_o}, exp);
    endtask
    task automatic give_verdict;
        if (err_count == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        repeat (2) @(posedge clock_i);
        reset_i <= 1'b0;
        @(posedge clock_i);
        bus(1'b0, `SPIM_IDX_CTRL, 8'h00);
        chk(rd, 8'h0C);
        bus(1'b0, `SPIM_IDX_STAT, 8'h00);
        chk(rd, 8'hA0);
        bus(1'b0, `SPIM_IDX_DIV, 8'h00);
        chk(rd, `SPIM_DIV_RST);
        bus(1'b1, 8'h10, 8'h5A);
        bus(1'b0, 8'h10, 8'h00);
        chk(rd, 8'h00);
        // Every mode; the low mode bit also picks the select pin
        for (k = 0; k < 4; k = k + 1) begin
            mode_q <= k[1:0];
            seed = xs(seed);
            bus(1'b1, `SPIM_IDX_DIV, {6'h0, seed[1:0]});
            bus(1'b1, `SPIM_IDX_CTRL, {6'h03, k[1:0]});
            repeat (3) @(posedge clock_i);
            chk({7'h0, sck_o}, {7'h0, k[1]});
            bus(1'b1, `SPIM_IDX_CTRL, {2'h0, k[0], 3'h7, k[1:0]});
            repeat (2) @(posedge clock_i);
            chk({6'h0, flash_select_1_n_o, flash_select_0_n_o}, k[0] ? 8'h01 : 8'h02);
            send(4);
            recv;
            bus(1'b1, `SPIM_IDX_CTRL, {6'h03, k[1:0]});
        end
        // Receive overrun: seventeen bytes with nothing read
        mode_q <= 2'h0;
        bus(1'b1, `SPIM_IDX_CTRL, 8'h0C);
        bus(1'b1, `SPIM_IDX_DIV, 8'h00);
        bus(1'b1, `SPIM_IDX_CTRL, 8'h1C);
        send(17);
        bus(1'b0, `SPIM_IDX_STAT, 8'h00);
        chk(rd, 8'h98);
        void'(exp_q.pop_back());
        recv;
        bus(1'b0, `SPIM_IDX_STAT, 8'h00);
        chk(rd, 8'hA8);
        bus(1'b1, `SPIM_IDX_STAT, 8'h08);
        bus(1'b0, `SPIM_IDX_STAT, 8'h00);
        chk(rd, 8'hA0);
        // Transmit overrun under a slow clock, then the interrupt gate
        bus(1'b1, `SPIM_IDX_CTRL, 8'h0C);
        bus(1'b1, `SPIM_IDX_DIV, 8'hFF);
        bus(1'b1, `SPIM_IDX_CTRL, 8'h1C);
        for (i = 0; i < 18; i = i + 1) bus(1'b1, `SPIM_IDX_DATA, 8'hA5);
        bus(1'b0, `SPIM_IDX_STAT, 8'h00);
        chk(rd & 8'hFB, 8'h68);
        irq_is(8'h54, 8'h01);
        irq_is(8'h14, 8'h00);
        irq_is(8'h5C, 8'h00);
        bus(1'b0, `SPIM_IDX_STAT, 8'h00);
        chk(rd & 8'hFB, 8'h68);
        // Dropping select mid-byte flushes and idles the engine
        bus(1'b1, `SPIM_IDX_CTRL, 8'h0C);
        irq_is(8'h48, 8'h01);
        bus(1'b0, `SPIM_IDX_STAT, 8'h00);
        chk(rd, 8'hAC);
        bus(1'b1, `SPIM_IDX_STAT, 8'h0C);
        irq_is(8'h48, 8'h00);
        give_verdict();
    end
endmodule // tb_spim_top
`default_nettype wire
